// File: design/qnt_pkg.sv
// Constants for the quad nibble timer unit: register indexes, field bits,
// reset values and clock rates.
// Assumes a 100 MHz APB clock; register indexes are word numbers on the bus.
package qnt_pkg;

  // System clock and low-speed time-base rate
  localparam int QNT_SYS_CLK_KHZ = 100000;
  localparam real QNT_LS_FREQ_KHZ = 32.768;
  // Half period of the low-speed clock, rounded to the nearest cycle
  localparam int QNT_LS_HALF_CYCLES = int'(real'(QNT_SYS_CLK_KHZ) / (2.0 * QNT_LS_FREQ_KHZ));
  localparam logic [10:0] QNT_LS_LAST = 11'(QNT_LS_HALF_CYCLES - 1);

  // Register indexes (byte address is four times the index)
  localparam logic [9:0] QNT_T0_DATA_LO_IDX = 10'h068;
  localparam logic [9:0] QNT_T0_DATA_HI_IDX = 10'h069;
  localparam logic [9:0] QNT_T1_DATA_LO_IDX = 10'h06a;
  localparam logic [9:0] QNT_T1_DATA_HI_IDX = 10'h06b;
  localparam logic [9:0] QNT_T0_CNT_LO_IDX = 10'h06c;
  localparam logic [9:0] QNT_T0_CNT_HI_IDX = 10'h06d;
  localparam logic [9:0] QNT_T1_CNT_LO_IDX = 10'h06e;
  localparam logic [9:0] QNT_T1_CNT_HI_IDX = 10'h06f;
  localparam logic [9:0] QNT_T0_MODE_IDX = 10'h070;
  localparam logic [9:0] QNT_T0_CLK_IDX = 10'h071;
  localparam logic [9:0] QNT_T1_MODE_IDX = 10'h072;
  localparam logic [9:0] QNT_T1_CLK_IDX = 10'h073;
  localparam logic [9:0] QNT_T0_STAT_IDX = 10'h074;
  localparam logic [9:0] QNT_T1_STAT_IDX = 10'h075;
  localparam logic [9:0] QNT_T2_DATA_LO_IDX = 10'h076;
  localparam logic [9:0] QNT_T2_DATA_HI_IDX = 10'h077;
  localparam logic [9:0] QNT_T3_DATA_LO_IDX = 10'h078;
  localparam logic [9:0] QNT_T3_DATA_HI_IDX = 10'h079;
  localparam logic [9:0] QNT_T2_CNT_LO_IDX = 10'h07a;
  localparam logic [9:0] QNT_T2_CNT_HI_IDX = 10'h07b;
  localparam logic [9:0] QNT_T3_CNT_LO_IDX = 10'h07c;
  localparam logic [9:0] QNT_T3_CNT_HI_IDX = 10'h07d;
  localparam logic [9:0] QNT_T2_MODE_IDX = 10'h07e;
  localparam logic [9:0] QNT_T2_CLK_IDX = 10'h07f;
  localparam logic [9:0] QNT_T3_MODE_IDX = 10'h080;
  localparam logic [9:0] QNT_T3_CLK_IDX = 10'h081;
  localparam logic [9:0] QNT_T2_STAT_IDX = 10'h082;
  localparam logic [9:0] QNT_T3_STAT_IDX = 10'h083;
  localparam logic [9:0] QNT_FIRST_IDX = QNT_T0_DATA_LO_IDX;
  localparam logic [9:0] QNT_LAST_IDX = QNT_T3_STAT_IDX;

  // Per-timer tables, timer 0 in the lowest slot
  localparam logic [3:0][9:0] QNT_DATA_LO = {QNT_T3_DATA_LO_IDX, QNT_T2_DATA_LO_IDX,
                                             QNT_T1_DATA_LO_IDX, QNT_T0_DATA_LO_IDX};
  localparam logic [3:0][9:0] QNT_DATA_HI = {QNT_T3_DATA_HI_IDX, QNT_T2_DATA_HI_IDX,
                                             QNT_T1_DATA_HI_IDX, QNT_T0_DATA_HI_IDX};
  localparam logic [3:0][9:0] QNT_CNT_LO = {QNT_T3_CNT_LO_IDX, QNT_T2_CNT_LO_IDX,
                                            QNT_T1_CNT_LO_IDX, QNT_T0_CNT_LO_IDX};
  localparam logic [3:0][9:0] QNT_CNT_HI = {QNT_T3_CNT_HI_IDX, QNT_T2_CNT_HI_IDX,
                                            QNT_T1_CNT_HI_IDX, QNT_T0_CNT_HI_IDX};
  localparam logic [3:0][9:0] QNT_MODE = {QNT_T3_MODE_IDX, QNT_T2_MODE_IDX,
                                          QNT_T1_MODE_IDX, QNT_T0_MODE_IDX};
  localparam logic [3:0][9:0] QNT_CLK = {QNT_T3_CLK_IDX, QNT_T2_CLK_IDX,
                                         QNT_T1_CLK_IDX, QNT_T0_CLK_IDX};
  localparam logic [3:0][9:0] QNT_STAT = {QNT_T3_STAT_IDX, QNT_T2_STAT_IDX,
                                          QNT_T1_STAT_IDX, QNT_T0_STAT_IDX};

  // Reset values; set bits are unimplemented and read as one
  localparam logic [3:0][3:0] QNT_MODE_RST = {4'he, 4'ha, 4'hc, 4'h8};
  localparam logic [3:0] QNT_CLK_RST = 4'hc;
  localparam logic [3:0][3:0] QNT_STAT_RST = {4'he, 4'he, 4'hc, 4'hc};

  // Field positions
  localparam int QNT_RUN_BIT = 0;
  localparam int QNT_ECAP_BIT = 1;
  localparam int QNT_FMEAS_BIT = 2;
  localparam int QNT_OVF_BIT = 0;
  localparam int QNT_CAP_BIT = 1;

  // Clock select codes
  localparam logic [1:0] QNT_SEL_LOW = 2'h0;
  localparam logic [1:0] QNT_SEL_FAST = 2'h1;
  localparam logic [1:0] QNT_SEL_EXT = 2'h2;
  localparam logic [1:0] QNT_SEL_PAIR = 2'h3;

endpackage

// File: design/qnt_timer_unit.sv
// Quad nibble timer unit: four 8-bit up-counters with nibble registers on APB.
// Assumes pins and the fast clock level are synchronous to pclk.
//
// Implementation choice: register access over APB.
module qnt_timer_unit
  import qnt_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer clock sources
  input wire logic fast_clock,
  input wire logic even_timers_ext_clock_pin,
  input wire logic odd_timers_ext_clock_pin,
  // Capture inputs
  input wire logic port_b_line_zero,
  input wire logic port_b_line_one,
  // Overflow requests and toggle outputs
  output logic [3:0] timer_irq,
  output logic timer0_overflow_toggle,
  output logic timer1_overflow_toggle
);

  typedef struct packed {
    logic [3:0][7:0] cnt;
    logic [3:0][7:0] dat;
    logic [3:0][3:0] mode;
    logic [3:0][1:0] csel;
    logic [3:0] ovf;
    logic [1:0] cap;
    logic [3:0] clk_prev;
    logic [1:0] pin_prev;
    logic [10:0] ls_cnt;
    logic ls_lvl;
    logic [3:0] irq;
    logic [31:0] rdata;
  } qnt_state_t;

  qnt_state_t s;
  qnt_state_t next_s;

  logic setup_ph;
  logic acc_ph;
  logic wr_en;
  logic addr_ok;
  logic [9:0] idx;
  logic [3:0] src_lvl;
  logic [3:0] tick;
  logic [3:0] pair;
  logic [3:0] run;
  logic [3:0] capmode;
  logic [3:0] ovf_pulse;
  logic [1:0] cap_edge;
  logic [1:0] cap_set;

  // Register hit: index matches and the ok flag is set; the caller picks the phase
  function automatic logic hit(input logic [9:0] a, input logic [9:0] r, input logic ok);
    return ok && (a == r);
  endfunction

  assign idx = paddr[11:2];
  assign setup_ph = psel & ~penable;
  assign acc_ph = psel & penable;
  assign wr_en = acc_ph & pwrite;
  assign addr_ok = (paddr[1:0] == 2'h0) && (idx >= QNT_FIRST_IDX) && (idx <= QNT_LAST_IDX);

  // Zero wait states; read data is latched in the setup phase
  assign pready = 1'b1;
  assign pslverr = acc_ph & ~addr_ok;
  assign prdata = s.rdata;
  assign timer_irq = s.irq;
  assign timer0_overflow_toggle = s.ovf[0];
  assign timer1_overflow_toggle = s.ovf[1];

  // Capture pin level changes, one per capture input
  assign cap_edge[0] = port_b_line_zero ^ s.pin_prev[0];
  assign cap_edge[1] = port_b_line_one ^ s.pin_prev[1];

  // Next-state logic for the whole unit
  always_comb begin
    next_s = s;
    next_s.irq = 4'h0;
    next_s.pin_prev = {port_b_line_one, port_b_line_zero};
    src_lvl = 4'h0;
    tick = 4'h0;
    pair = 4'h0;
    run = 4'h0;
    capmode = 4'h0;
    ovf_pulse = 4'h0;
    cap_set = 2'h0;

    if (s.ls_cnt == QNT_LS_LAST) begin
      next_s.ls_cnt = 11'h000;
      next_s.ls_lvl = ~s.ls_lvl;
    end else begin
      next_s.ls_cnt = s.ls_cnt + 11'h001;
    end

    for (int i = 0; i < 4; i++) begin
      // odd timer paired to its even neighbour
      pair[i] = (i % 2 == 1) && (s.csel[i] == QNT_SEL_PAIR);
      case (s.csel[i])
        QNT_SEL_LOW: src_lvl[i] = s.ls_lvl;
        QNT_SEL_FAST: src_lvl[i] = fast_clock;
        // shared external pins; sampled by pclk
        QNT_SEL_EXT: src_lvl[i] = (i % 2 == 0) ? even_timers_ext_clock_pin
                                                : odd_timers_ext_clock_pin;
        default: src_lvl[i] = 1'b0;
      endcase
      next_s.clk_prev[i] = src_lvl[i];
      // falling edge of the selected clock
      tick[i] = s.clk_prev[i] & ~src_lvl[i];
      if (pair[i]) begin
        // even overflow drives odd timer
        // Neighbour index written so it stays in range when i is even
        tick[i] = ovf_pulse[i - i % 2];
        run[i] = s.mode[i - i % 2][QNT_RUN_BIT];
      end else begin
        run[i] = s.mode[i][QNT_RUN_BIT];
      end
      // timers 2 and 3 have no capture mode
      capmode[i] = (i < 2) && s.mode[i][QNT_ECAP_BIT] && !s.mode[i][QNT_FMEAS_BIT];

      // count, with overflow and reload after 8'hff
      if (tick[i] && run[i]) begin
        if (s.cnt[i] == 8'hff) begin
          ovf_pulse[i] = 1'b1;
          // reload; capture mode restarts from zero
          next_s.cnt[i] = capmode[i] ? 8'h00 : s.dat[i];
        end else begin
          next_s.cnt[i] = s.cnt[i] + 8'h01;
        end
      end
      if (ovf_pulse[i]) begin
        next_s.ovf[i] = ~s.ovf[i];
      end
      next_s.irq[i] = ovf_pulse[i];
    end

    // status read clears only a flag that was seen set
    for (int i = 0; i < 2; i++) begin
      if (acc_ph && !pwrite && hit(idx, QNT_STAT[i], addr_ok) && s.rdata[QNT_CAP_BIT]) begin
        next_s.cap[i] = 1'b0;
      end
    end

    // capture only while flag is clear
    // Paired capture takes its trigger from the timer 0 pin
    for (int i = 0; i < 2; i++) begin
      if (capmode[i] && run[i] && !s.cap[i]) begin
        cap_set[i] = pair[i] ? cap_edge[0] : cap_edge[i];
      end
      if (cap_set[i]) begin
        next_s.dat[i] = s.cnt[i];
        // flag set wins over a read clear
        next_s.cap[i] = 1'b1;
      end
    end

    // Software writes; a write wins over a count in the same cycle
    if (wr_en && addr_ok) begin
      for (int i = 0; i < 4; i++) begin
        if (hit(idx, QNT_DATA_LO[i], 1'b1)) begin
          next_s.dat[i][3:0] = pwdata[3:0];
        end
        if (hit(idx, QNT_DATA_HI[i], 1'b1)) begin
          next_s.dat[i][7:4] = pwdata[3:0];
        end
        if (hit(idx, QNT_CNT_LO[i], 1'b1)) begin
          next_s.cnt[i][3:0] = pwdata[3:0];
          next_s.dat[i][3:0] = pwdata[3:0];
        end
        if (hit(idx, QNT_CNT_HI[i], 1'b1)) begin
          next_s.cnt[i][7:4] = pwdata[3:0];
          next_s.dat[i][7:4] = pwdata[3:0];
        end
        if (hit(idx, QNT_MODE[i], 1'b1)) begin
          next_s.mode[i] = pwdata[3:0] & ~QNT_MODE_RST[i];
        end
        if (hit(idx, QNT_CLK[i], 1'b1)) begin
          next_s.csel[i] = pwdata[1:0];
        end
      end
    end

    // Read mux in the setup phase; unmapped reads give zero
    if (setup_ph && !pwrite) begin
      next_s.rdata = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
        if (hit(idx, QNT_DATA_LO[i], addr_ok)) next_s.rdata[3:0] = s.dat[i][3:0];
        if (hit(idx, QNT_DATA_HI[i], addr_ok)) next_s.rdata[3:0] = s.dat[i][7:4];
        if (hit(idx, QNT_CNT_LO[i], addr_ok)) next_s.rdata[3:0] = s.cnt[i][3:0];
        if (hit(idx, QNT_CNT_HI[i], addr_ok)) next_s.rdata[3:0] = s.cnt[i][7:4];
        if (hit(idx, QNT_MODE[i], addr_ok)) next_s.rdata[3:0] = s.mode[i] | QNT_MODE_RST[i];
        if (hit(idx, QNT_CLK[i], addr_ok)) next_s.rdata[3:0] = {2'h0, s.csel[i]} | QNT_CLK_RST;
        if (hit(idx, QNT_STAT[i], addr_ok)) begin
          // only timers 0 and 1 carry a capture flag
          next_s.rdata[3:0] = QNT_STAT_RST[i];
          next_s.rdata[QNT_OVF_BIT] = s.ovf[i];
          if (i < 2) next_s.rdata[QNT_CAP_BIT] = s.cap[i];
        end
      end
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.cnt <= '0;
      s.dat <= '0;
      s.mode <= '0;
      s.csel <= '0;
      s.ovf <= 4'h0;
      s.cap <= 2'h0;
      s.clk_prev <= 4'h0;
      s.pin_prev <= 2'h0;
      s.ls_cnt <= 11'h000;
      s.ls_lvl <= 1'b0;
      s.irq <= 4'h0;
      s.rdata <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  default clocking qnt_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_read_clears_cap: assert property (
    acc_ph && !pwrite && idx == QNT_T0_STAT_IDX && paddr[1:0] == 2'h0
      && prdata[QNT_CAP_BIT] && !cap_set[0] |=> !s.cap[0])
    else $error("capture flag not cleared by status read");

  a_cap_sets_flag: assert property (
    cap_set[0] && !wr_en |=> s.cap[0] && s.dat[0] == $past(s.cnt[0]))
    else $error("capture did not set flag or copy counter");

  a_cap_blocks_more: assert property (
    s.cap[0] && !wr_en ##1 s.cap[0] |-> $stable(s.dat[0]))
    else $error("held capture value overwritten");

  a_ovf_toggles: assert property (
    ovf_pulse[1] |=> s.ovf[1] != $past(s.ovf[1]))
    else $error("overflow flag did not invert");

  a_reload_on_ovf: assert property (
    ovf_pulse[0] && !capmode[0] && !wr_en |=> s.cnt[0] == $past(s.dat[0]))
    else $error("counter not reloaded on overflow");

  a_cnt_write_copy: assert property (
    wr_en && paddr == {QNT_T2_CNT_HI_IDX, 2'h0}
      |=> s.cnt[2][7:4] == $past(pwdata[3:0]) && s.dat[2][7:4] == $past(pwdata[3:0]))
    else $error("counter write not copied to data");

  a_data_write_keeps: assert property (
    wr_en && paddr == {QNT_T0_DATA_LO_IDX, 2'h0} && !tick[0] |=> $stable(s.cnt[0]))
    else $error("data write changed counter");

  a_pair_clock: assert property (
    pair[3] |-> tick[3] == ovf_pulse[2] && run[3] == s.mode[2][QNT_RUN_BIT])
    else $error("paired timer not clocked by even overflow");

  a_irq_pulse: assert property (
    ovf_pulse[2] |=> timer_irq[2] ##1 !timer_irq[2] || $past(ovf_pulse[2]))
    else $error("overflow request missing");

  a_unimpl_ones: assert property (
    setup_ph && !pwrite && paddr == {QNT_T3_STAT_IDX, 2'h0} |=> prdata[3:1] == 3'h7)
    else $error("unimplemented status bits not read as one");

  a_ext_shared: assert property (
    s.csel[0] == QNT_SEL_EXT && s.csel[2] == QNT_SEL_EXT |-> src_lvl[0] == src_lvl[2])
    else $error("even timers not sharing external clock pin");

  a_ext_odd_shared: assert property (
    s.csel[1] == QNT_SEL_EXT && s.csel[3] == QNT_SEL_EXT |-> src_lvl[1] == src_lvl[3])
    else $error("odd timers not sharing external clock pin");

  // Reset state, second capture flag, status layout and data nibble read
  a_reset_flags_clear: assert property (
    $rose(presetn) |-> s.ovf == 4'h0 && s.cap == 2'h0)
    else $error("status flags not clear after reset");

  a_t1_capture_set: assert property (
    cap_set[1] && !wr_en |=> s.cap[1] && s.dat[1] == $past(s.cnt[1]))
    else $error("timer 1 capture did not set its flag");

  a_t1_read_clears: assert property (
    acc_ph && !pwrite && paddr == {QNT_T1_STAT_IDX, 2'h0} && prdata[QNT_CAP_BIT]
      |=> !s.cap[1])
    else $error("timer 1 capture flag not cleared by read");

  a_t2_status_bits: assert property (
    setup_ph && !pwrite && paddr == {QNT_T2_STAT_IDX, 2'h0}
      |=> prdata[3:0] == {3'h7, $past(s.ovf[2])})
    else $error("timer 2 status layout wrong");

  a_nibble_read: assert property (
    setup_ph && !pwrite && paddr == {QNT_T1_DATA_HI_IDX, 2'h0}
      |=> prdata == {28'h0000000, $past(s.dat[1][7:4])})
    else $error("data high nibble read wrong");

  // Low-speed divider; a full period is twice the half count
  a_ls_divider: assert property (
    s.ls_cnt == QNT_LS_LAST |=> s.ls_cnt == 11'h000 && s.ls_lvl != $past(s.ls_lvl))
    else $error("low-speed level did not turn at end of half period");

  a_ls_range: assert property (
    s.ls_cnt <= QNT_LS_LAST)
    else $error("low-speed divider out of range");

  // Counting only on a sampled falling level; a write takes precedence
  a_fall_counts: assert property (
    s.clk_prev[0] && !src_lvl[0] && s.mode[0][QNT_RUN_BIT] && s.cnt[0] != 8'hff && !wr_en
      |=> s.cnt[0] == $past(s.cnt[0]) + 8'h01)
    else $error("counter did not step on falling clock");

  a_cnt_holds_idle: assert property (
    !(s.clk_prev[0] && !src_lvl[0]) && !wr_en |=> $stable(s.cnt[0]))
    else $error("counter moved without a falling clock");

  a_fast_source: assert property (
    s.csel[3] == QNT_SEL_FAST |-> src_lvl[3] == fast_clock)
    else $error("fast clock select not decoded");

  c_capture: cover property (cap_set[1]);
  c_pair_overflow: cover property (pair[1] && ovf_pulse[1]);
  c_read_clear: cover property (s.cap[0] ##1 !s.cap[0]);
  c_reload: cover property (ovf_pulse[3] && !pair[3]);
  c_low_speed_tick: cover property (tick[2] && run[2] && s.csel[2] == QNT_SEL_LOW);

endmodule // qnt_timer_unit

// File: bench/qnt_pin_model.sv
// Pin-side partner: drives the two external timer clock pins and the two
// capture pins. Assumes the bench calls one task at a time from one process.
module qnt_pin_model (
  // System clock
  input wire logic pclk,
  // Pins towards the timer unit
  output logic even_pin,
  output logic odd_pin,
  output logic cap0_pin,
  output logic cap1_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins idle low; clock pins stand still between bursts
  initial begin
    even_pin = 1'b0;
    odd_pin = 1'b0;
    cap0_pin = 1'b0;
    cap1_pin = 1'b0;
  end

  // shared pins, long levels
  // Each level lasts at least two system clocks so no level is missed
  task automatic pulse(input int which, input int n, input int hold);
    repeat (n) begin
      for (int lvl = 1; lvl >= 0; lvl--) begin
        @(posedge pclk);
        if (which == 0) even_pin <= lvl[0];
        else odd_pin <= lvl[0];
        repeat (hold - 1) @(posedge pclk);
      end
    end
  endtask

  // Capture input level change
  task automatic flip(input int which);
    @(posedge pclk);
    if (which == 0) cap0_pin <= ~cap0_pin;
    else cap1_pin <= ~cap1_pin;
  endtask
endmodule // qnt_pin_model

// File: bench/tb_qnt_timer_unit.sv
// Testbench for the quad nibble timer unit: APB traffic, pin clocks, captures
// and pairing, each result checked against a behavioural model.
// Assumes the pin model drives clock and capture pins; the bench drives APB.
module tb_qnt_timer_unit
  import qnt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fast_clock;
  logic even_pin, odd_pin, cap0_pin, cap1_pin, tog0, tog1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] timer_irq;
  int cnt[4], dat[4], md[4], ck[4], ovf[4], cap[4], irqs[4], seen[4];
  int failures, checks;
  integer seed = 32'he670e390;

  qnt_timer_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fast_clock(fast_clock), .even_timers_ext_clock_pin(even_pin),
    .odd_timers_ext_clock_pin(odd_pin), .port_b_line_zero(cap0_pin),
    .port_b_line_one(cap1_pin), .timer_irq(timer_irq), .timer0_overflow_toggle(tog0),
    .timer1_overflow_toggle(tog1));
  qnt_pin_model pm_u (.pclk(pclk), .even_pin(even_pin), .odd_pin(odd_pin),
    .cap0_pin(cap0_pin), .cap1_pin(cap1_pin));

  // 100 MHz clock
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // Count overflow requests seen per timer
  always @(posedge pclk) begin
    for (int t = 0; t < 4; t++) begin
      if (timer_irq[t] === 1'b1) seen[t]++;
    end
  end

  // Model: one count tick; an even overflow clocks a paired odd timer
  function automatic void m_tick(input int t);
    if (cnt[t] == 255) begin
      ovf[t] ^= 1;
      irqs[t]++;
      cnt[t] = (t < 2 && md[t][1] && !md[t][2]) ? 0 : dat[t];
      if (t % 2 == 0 && ck[t + 1] == 3) m_tick(t + 1);
    end else cnt[t]++;
  endfunction

  // Model: a falling edge of source src (pin 0 even, 1 odd for external)
  function automatic void m_src(input int src, input int pin);
    for (int t = 0; t < 4; t++) begin
      if (ck[t] == src && (src != 2 || t % 2 == pin) && md[t][0]) m_tick(t);
    end
  endfunction

  // Model: register read value, unimplemented bits read one
  function automatic logic [31:0] m_read(input int idx);
    for (int t = 0; t < 4; t++) begin
      if (idx == QNT_DATA_LO[t]) return dat[t] & 15;
      if (idx == QNT_DATA_HI[t]) return dat[t] >> 4;
      if (idx == QNT_CNT_LO[t]) return cnt[t] & 15;
      if (idx == QNT_CNT_HI[t]) return cnt[t] >> 4;
      if (idx == QNT_MODE[t]) return QNT_MODE_RST[t] | md[t];
      if (idx == QNT_CLK[t]) return 12 | ck[t];
      if (idx == QNT_STAT[t]) return QNT_STAT_RST[t] | (cap[t] << 1) | ovf[t];
    end
    return 0;
  endfunction

  // Model: register write; count writes also land in the data nibble
  function automatic void m_write(input int idx, input int v);
    for (int t = 0; t < 4; t++) begin
      if (idx == QNT_DATA_LO[t] || idx == QNT_CNT_LO[t]) dat[t] = (dat[t] & 'hf0) | v;
      if (idx == QNT_DATA_HI[t] || idx == QNT_CNT_HI[t]) dat[t] = (dat[t] & 'h0f) | (v << 4);
      if (idx == QNT_CNT_LO[t]) cnt[t] = (cnt[t] & 'hf0) | v;
      if (idx == QNT_CNT_HI[t]) cnt[t] = (cnt[t] & 'h0f) | (v << 4);
      if (idx == QNT_MODE[t]) md[t] = v & ~int'(QNT_MODE_RST[t]) & 15;
      if (idx == QNT_CLK[t]) ck[t] = v & 3;
    end
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // APB transfer; read data and error taken at the edge that sees pready
  task automatic xfer(input logic wr, input int idx, input int v);
    logic [31:0] rd;
    logic err;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= 12'(idx * 4);
    pwdata <= 32'(v);
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, err}, idx < QNT_FIRST_IDX || idx > QNT_LAST_IDX);
    if (wr) m_write(idx, v);
    else begin
      chk(rd, m_read(idx));
      for (int t = 0; t < 2; t++) if (idx == QNT_STAT[t]) cap[t] = 0;
    end
  endtask

  task automatic rd_all();
    for (int i = QNT_FIRST_IDX; i <= QNT_LAST_IDX + 1; i++) xfer(1'b0, i, 0);
    chk({tog1, tog0}, {ovf[1][0], ovf[0][0]});
  endtask

  task automatic pls(input int which, input int n);
    pm_u.pulse(which, n, 2 + ($unsigned($random(seed)) % 4));
    repeat (4) @(posedge pclk);
    repeat (n) m_src(2, which);
  endtask

  task automatic capt(input int which);
    pm_u.flip(which);
    repeat (4) @(posedge pclk);
    if (md[which][1] && !md[which][2] && md[which][0] && !cap[which]) begin
      dat[which] = cnt[which];
      cap[which] = 1;
    end
  endtask

  task automatic complete_run();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #500us;
    failures++;
    complete_run();
  end

  initial begin
    {psel, penable, pwrite, fast_clock, presetn} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_all();
    // Random nibbles everywhere, run bits kept clear
    for (int i = QNT_FIRST_IDX; i <= QNT_LAST_IDX + 1; i++)
      xfer(1'b1, i, $unsigned($random(seed)) & ((i inside {QNT_T0_MODE_IDX, QNT_T1_MODE_IDX,
        QNT_T2_MODE_IDX, QNT_T3_MODE_IDX}) ? 14 : 15));
    rd_all();
    // Timer 0 on the even pin, timer 1 paired on its overflow
    xfer(1'b1, QNT_T0_CLK_IDX, 2);
    xfer(1'b1, QNT_T1_CLK_IDX, 3);
    xfer(1'b1, QNT_T0_CNT_LO_IDX, 'hd);
    xfer(1'b1, QNT_T0_CNT_HI_IDX, 'hf);
    xfer(1'b1, QNT_T1_CNT_LO_IDX, 'he);
    xfer(1'b1, QNT_T1_CNT_HI_IDX, 'hf);
    xfer(1'b1, QNT_T2_MODE_IDX, 0);
    xfer(1'b1, QNT_T1_MODE_IDX, 0);
    xfer(1'b1, QNT_T0_MODE_IDX, 1);
    pls(0, 6);
    rd_all();
    // Timers 2 and 3 on the shared pins, then fast clock, then paired
    xfer(1'b1, QNT_T0_MODE_IDX, 0);
    xfer(1'b1, QNT_T2_CLK_IDX, 2);
    xfer(1'b1, QNT_T3_CLK_IDX, 2);
    xfer(1'b1, QNT_T2_MODE_IDX, 1);
    xfer(1'b1, QNT_T3_MODE_IDX, 1);
    pls(0, 2);
    pls(1, 3);
    xfer(1'b1, QNT_T3_CLK_IDX, 1); // fast level held still until now
    repeat (5) begin
      repeat (2) @(posedge pclk);
      fast_clock <= 1'b1;
      repeat (2) @(posedge pclk);
      fast_clock <= 0;
      m_src(1, 0);
    end
    xfer(1'b1, QNT_T3_CLK_IDX, 3);
    xfer(1'b1, QNT_T2_CNT_LO_IDX, 'he);
    xfer(1'b1, QNT_T2_CNT_HI_IDX, 'hf);
    pls(0, 3);
    rd_all();
    // Capture on timer 0, a second change ignored until status read
    xfer(1'b1, QNT_T0_MODE_IDX, 3);
    pls(0, 2);
    capt(0);
    pls(0, 1);
    capt(0);
    rd_all();
    capt(0);
    rd_all();
    // Capture on timer 1 from its own pin
    xfer(1'b1, QNT_T1_CLK_IDX, 2);
    xfer(1'b1, QNT_T1_MODE_IDX, 3);
    pls(1, 2);
    capt(1);
    rd_all();
    // Low-speed clock: two periods of 32.768 kHz give two counts
    // Stop first so no count slips in while the source changes
    xfer(1'b1, QNT_T2_MODE_IDX, 0);
    xfer(1'b1, QNT_T2_CLK_IDX, 0);
    xfer(1'b1, QNT_T2_CNT_LO_IDX, 0);
    xfer(1'b1, QNT_T2_CNT_HI_IDX, 0);
    xfer(1'b1, QNT_T2_MODE_IDX, 1);
    // Run window is 6104 edges, the stop transfer's three edges included
    repeat (6101) @(posedge pclk);
    xfer(1'b1, QNT_T2_MODE_IDX, 0);
    m_tick(2);
    m_tick(2);
    rd_all();
    for (int t = 0; t < 4; t++) chk(seen[t], irqs[t]);
    complete_run();
  end
endmodule // tb_qnt_timer_unit
